// File: bench/iops_core_asserts.sv
`timescale 1ns/10ps
module iops_core_asserts (
   input wire logic ref_clk_in, // Clock
   input wire logic rst_n_in, // Reset, active low
   input wire logic req_valid_in, // Request valid
   input wire iops_pkg::iops_req_t req_in, // Request
   input wire logic [31:0] block_data_in, // Block store data
   input wire iops_pkg::iops_resp_t resp_out, // Response
   input wire logic done_out, // Completion pulse
   input wire logic [31:0] psr_out // Status word
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   logic tk;
   logic [31:0] andv;
   logic [31:0] prod;
   iops_pkg::iops_op_t op;
   assign tk = req_valid_in && !resp_out.busy;
   assign op = req_in.op;
   assign andv = req_in.first_operand_reg & req_in.second_operand;
   // Low word only, as the result register keeps
   assign prod = req_in.second_src_reg * req_in.multiplier_reg;
   load_result_a: assert property (tk && op == iops_pkg::IOPS_WORD_LOAD_OP |=>
      resp_out.reg_we && resp_out.reg_wdata == $past(req_in.mem_rdata)) else $error("load bad");
   product_low_a: assert property (tk && op == iops_pkg::IOPS_PRODUCT_OP |=>
      resp_out.reg_we && resp_out.reg_wdata == $past(prod)) else $error("product bad");
   invert_copy_a: assert property (tk && op == iops_pkg::IOPS_INVERTED_COPY_OP |=>
      resp_out.reg_wdata == ~$past(req_in.second_operand)) else $error("invert bad");
   test_no_write_a: assert property (tk && (op == iops_pkg::IOPS_XOR_TEST_OP ||
      op == iops_pkg::IOPS_AND_TEST_OP) |=> !resp_out.reg_we && done_out)
      else $error("test op wrote a register");
   and_flags_a: assert property (tk && op == iops_pkg::IOPS_AND_TEST_OP |=>
      psr_out[30] == ($past(andv) == 32'h0) && psr_out[31] == $past(andv[31]) &&
      psr_out[28] == $past(psr_out[28])) else $error("logical flags bad");
   flags_kept_a: assert property (tk && !req_in.set_flags &&
      op inside {iops_pkg::IOPS_COPY_OP, iops_pkg::IOPS_DIFFERENCE_OP} |=>
      psr_out == $past(psr_out)) else $error("flags changed without set");
   no_borrow_a: assert property (tk && op == iops_pkg::IOPS_DIFFERENCE_OP &&
      req_in.set_flags |=>
      psr_out[29] == ($past(req_in.first_operand_reg) >= $past(req_in.second_operand)))
      else $error("carry bad");
   swap_order_a: assert property (tk && op == iops_pkg::IOPS_ATOMIC_EXCHANGE_OP |=>
      resp_out.mem_re && resp_out.reg_we ##1 resp_out.mem_we && done_out) else $error("swap bad");
   copy_value_a: assert property (tk && op == iops_pkg::IOPS_COPY_OP |=>
      done_out && resp_out.reg_wdata == $past(req_in.second_operand)) else $error("copy bad");
   block_c: cover property (tk && op == iops_pkg::IOPS_BLOCK_STORE_OP);
   swap_c: cover property (tk && op == iops_pkg::IOPS_ATOMIC_EXCHANGE_OP);
   flags_c: cover property (tk && req_in.set_flags);
endmodule
bind iops_core iops_core_asserts i_iops_core_asserts (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
   .block_data_in(block_data_in), .resp_out(resp_out), .done_out(done_out),
   .psr_out(psr_out));

// File: bench/tb_iops_core.sv
`timescale 1ns/10ps
module tb_iops_core;
   localparam logic [31:0] X = 32'h0001_0003;
   localparam logic [31:0] Y = 32'h0002_0005;
   localparam logic [31:0] AD = 32'h0000_0100;
   typedef struct {iops_pkg::iops_op_t op; logic [1:0] k; logic [31:0] e;} iops_row_t;
   // Kind 0 register, 1 memory, 2 coprocessor; carry is clear from reset
   iops_row_t rows [14] = '{
      '{iops_pkg::IOPS_WORD_LOAD_OP, 2'h0, Y},
      '{iops_pkg::IOPS_WORD_STORE_OP, 2'h1, X},
      '{iops_pkg::IOPS_CPU_TO_COPRO_OP, 2'h2, X},
      '{iops_pkg::IOPS_COPRO_TO_CPU_OP, 2'h0, Y},
      '{iops_pkg::IOPS_PRODUCT_OP, 2'h0, X * Y},
      '{iops_pkg::IOPS_PRODUCT_ACCUMULATE_OP, 2'h0, X * Y + X},
      '{iops_pkg::IOPS_COPY_OP, 2'h0, Y},
      '{iops_pkg::IOPS_INVERTED_COPY_OP, 2'h0, ~Y},
      '{iops_pkg::IOPS_BITWISE_OR_OP, 2'h0, X | Y},
      '{iops_pkg::IOPS_REVERSED_DIFFERENCE_OP, 2'h0, Y - X},
      '{iops_pkg::IOPS_REVERSED_BORROW_DIFFERENCE_OP, 2'h0, Y - X - 32'h1},
      '{iops_pkg::IOPS_DIFFERENCE_OP, 2'h0, X - Y},
      '{iops_pkg::IOPS_BORROW_DIFFERENCE_OP, 2'h0, X - Y - 32'h1},
      '{iops_pkg::IOPS_COPRO_STORE_OP, 2'h1, Y}};
   int idx [3] = '{0, 2, 15};
   int fails = 0;
   int checked = 0;
   logic ref_clk_in;
   logic rst_n_in = 1'b0;
   logic req_valid_in = 1'b0;
   iops_pkg::iops_req_t req_in = '0;
   logic [31:0] block_data_in;
   iops_pkg::iops_resp_t resp_out;
   logic done_out;
   logic [31:0] psr_out;
   // Combinational by contract, so it follows store_index at once
   assign block_data_in = 32'hb000_0000 | {28'h0, resp_out.store_index};
   iops_core i_iops_core (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .block_data_in(block_data_in),
      .resp_out(resp_out), .done_out(done_out), .psr_out(psr_out));
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Issues one request and returns just after the answer edge
   task automatic go(input iops_pkg::iops_op_t op, input logic [31:0] x, input logic [31:0] y,
                     input logic sf, input logic fo);
      iops_pkg::iops_req_t r;
      r = '0;
      r.op = op;
      r.set_flags = sf;
      r.flags_only = fo;
      r.first_operand_reg = x;
      r.second_operand = y;
      r.second_src_reg = x;
      r.multiplier_reg = y;
      r.dest_old = x;
      r.copro_target_reg = y;
      r.copro_extra_reg = 32'h0f00_0000;
      r.copro_combine = fo;
      r.address = AD;
      r.mem_rdata = y;
      r.reg_list = 16'h8005;
      @(posedge ref_clk_in);
      req_valid_in <= 1'b1;
      req_in <= r;
      @(posedge ref_clk_in);
      req_valid_in <= 1'b0;
      #1;
   endtask
   task automatic report_and_stop;
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (400) @(posedge ref_clk_in);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("psr_reset", 32'h0000_00d3, psr_out);
      chk("done_reset", 32'h0, 32'(done_out));
      foreach (rows[i]) begin
         go(rows[i].op, X, Y, 1'b0, 1'b0);
         if (rows[i].k == 2'h0) chk("reg_wdata", rows[i].e, resp_out.reg_wdata);
         if (rows[i].k == 2'h1) chk("mem_wdata", rows[i].e, resp_out.mem_wdata);
         if (rows[i].k == 2'h1) chk("mem_addr", AD, resp_out.mem_addr);
         if (rows[i].k == 2'h2) chk("copro_wdata", rows[i].e, resp_out.copro_wdata);
         chk("strobes", 32'(3'b100 >> rows[i].k),
            32'({resp_out.reg_we, resp_out.mem_we, resp_out.copro_we}));
         chk("psr_kept", 32'h0000_00d3, psr_out);
      end
      // Combine forms: flags_only doubles as the combine select in go
      go(iops_pkg::IOPS_CPU_TO_COPRO_OP, X, Y, 1'b0, 1'b1);
      chk("copro_comb", X | 32'h0f00_0000, resp_out.copro_wdata);
      go(iops_pkg::IOPS_COPRO_TO_CPU_OP, X, Y, 1'b0, 1'b1);
      chk("cpu_comb", Y | 32'h0f00_0000, resp_out.reg_wdata);
      go(iops_pkg::IOPS_DIFFERENCE_OP, X, X, 1'b1, 1'b0);
      chk("psr_sub", 32'h6000_00d3, psr_out);
      go(iops_pkg::IOPS_BORROW_DIFFERENCE_OP, X, X, 1'b0, 1'b0);
      chk("sbc_carry", 32'h0, resp_out.reg_wdata);
      go(iops_pkg::IOPS_REG_TO_STATUS_OP, 32'h1000_0000, 32'h0, 1'b0, 1'b1);
      chk("psr_flags", 32'h1000_00d3, psr_out);
      go(iops_pkg::IOPS_XOR_TEST_OP, 32'h8000_0000, 32'h0, 1'b0, 1'b0);
      chk("psr_xor", 32'h9000_00d3, psr_out);
      chk("xor_we", 32'h0, 32'(resp_out.reg_we));
      go(iops_pkg::IOPS_AND_TEST_OP, 32'hffff_ffff, 32'h0, 1'b0, 1'b0);
      chk("psr_and", 32'h5000_00d3, psr_out);
      go(iops_pkg::IOPS_REG_TO_STATUS_OP, 32'h2000_001f, 32'h0, 1'b0, 1'b0);
      chk("psr_full", 32'h2000_001f, psr_out);
      go(iops_pkg::IOPS_STATUS_TO_REG_OP, 32'h0, 32'h0, 1'b0, 1'b0);
      chk("psr_read", 32'h2000_001f, resp_out.reg_wdata);
      go(iops_pkg::IOPS_REVERSED_BORROW_DIFFERENCE_OP, X, Y, 1'b0, 1'b0);
      chk("rsc_carry", Y - X, resp_out.reg_wdata);
      go(iops_pkg::IOPS_BLOCK_STORE_OP, X, Y, 1'b0, 1'b0);
      foreach (idx[j]) begin
         @(posedge ref_clk_in);
         #1;
         chk("blk_addr", AD + 32'(4 * j), resp_out.mem_addr);
         chk("blk_data", 32'hb000_0000 | 32'(idx[j]), resp_out.mem_wdata);
         chk("blk_we", 32'h1, 32'(resp_out.mem_we));
      end
      chk("blk_done", 32'h1, 32'(done_out));
      go(iops_pkg::IOPS_ATOMIC_EXCHANGE_OP, X, Y, 1'b0, 1'b0);
      chk("swp_read", X, resp_out.mem_addr);
      chk("swp_load", Y, resp_out.reg_wdata);
      chk("swp_busy", 32'h3, 32'({resp_out.busy, resp_out.mem_re}));
      @(posedge ref_clk_in);
      #1;
      chk("swp_write", X, resp_out.mem_wdata);
      chk("swp_done", 32'h3, 32'({resp_out.mem_we, done_out}));
      // Reset in mid-run must restore the status word
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("psr_rerst", 32'h0000_00d3, psr_out);
      chk("busy_rerst", 32'h0, 32'(resp_out.busy));
      report_and_stop;
   end
endmodule

// File: design/iops_core.sv
// Summary of operation
// - Word load writes memory word to destination
// - Word store writes source register to memory
// - Register to coprocessor, optional combine
// - Coprocessor value, optional combine, to register
// - Product low word, accumulate adds old destination
// - Copy writes second operand unchanged
// - Inverted copy complements; or combines operands
// - Status word to register and back
// - Status write full or flags only
// - Reversed subtract, carry form minus one plus carry
// - Subtract, carry form minus one plus carry
// - Coprocessor store writes coprocessor register
// - Block store writes register list, ascending address
// - Atomic exchange loads then stores same word
// - Xor test updates flags only
// - And test updates flags only
// - Logical flags keep overflow, set zero, negative
// - Flag update by set bit for arithmetic and logical ops only; tests always
`timescale 1ns/10ps
`include "iops_params.svh"
module iops_core (
   input wire logic ref_clk_in, // 20 MHz clock
   input wire logic rst_n_in, // Synchronous reset, active low
   input wire logic req_valid_in, // Request present, taken when idle
   input wire iops_pkg::iops_req_t req_in, // Operation and operands
   input wire logic [31:0] block_data_in, // Register value for store_index
   output iops_pkg::iops_resp_t resp_out, // Results, registered
   output logic done_out, // One-cycle completion pulse
   output logic [31:0] psr_out // Current status word
);
   iops_pkg::iops_regs_t r;
   iops_pkg::iops_regs_t next_r;

   // Lowest set bit of a register list
   function automatic logic [3:0] lowest_bit(input logic [15:0] l);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (l[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [15:0] clear_lowest(input logic [15:0] l);
      return l & (l - 16'h0001);
   endfunction

   // 33-bit add gives carry out; a - b - 1 + c done as a + ~b + c
   function automatic logic [32:0] add_c(input logic [31:0] a, input logic [31:0] b,
                                          input logic cin);
      return {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
   endfunction

   logic [31:0] product;
   logic [31:0] copro_val;
   logic [32:0] arith;
   logic [31:0] arith_a;
   logic [31:0] arith_b;
   logic [31:0] logic_res;
   logic is_arith;
   logic is_logic;
   logic carry;

   always_comb begin
      carry = r.status_word[`IOPS_FLAG_C];
      product = 32'(req_in.second_src_reg * req_in.multiplier_reg);
      copro_val = req_in.copro_combine ?
         (req_in.copro_target_reg | req_in.copro_extra_reg) : req_in.copro_target_reg;
      arith_a = `IOPS_ZERO;
      arith_b = `IOPS_ZERO;
      is_arith = 1'b0;
      is_logic = 1'b0;
      logic_res = `IOPS_ZERO;
      unique case (req_in.op)
         iops_pkg::IOPS_REVERSED_DIFFERENCE_OP,
         iops_pkg::IOPS_REVERSED_BORROW_DIFFERENCE_OP: begin
            arith_a = req_in.second_operand;
            arith_b = ~req_in.first_operand_reg;
            is_arith = 1'b1;
         end
         iops_pkg::IOPS_DIFFERENCE_OP,
         iops_pkg::IOPS_BORROW_DIFFERENCE_OP: begin
            arith_a = req_in.first_operand_reg;
            arith_b = ~req_in.second_operand;
            is_arith = 1'b1;
         end
         iops_pkg::IOPS_COPY_OP: begin
            logic_res = req_in.second_operand;
            is_logic = 1'b1;
         end
         iops_pkg::IOPS_INVERTED_COPY_OP: begin
            logic_res = `IOPS_ONES ^ req_in.second_operand;
            is_logic = 1'b1;
         end
         iops_pkg::IOPS_BITWISE_OR_OP: begin
            logic_res = req_in.first_operand_reg | req_in.second_operand;
            is_logic = 1'b1;
         end
         iops_pkg::IOPS_XOR_TEST_OP: begin
            logic_res = req_in.first_operand_reg ^ req_in.second_operand;
            is_logic = 1'b1;
         end
         iops_pkg::IOPS_AND_TEST_OP: begin
            logic_res = req_in.first_operand_reg & req_in.second_operand;
            is_logic = 1'b1;
         end
         default: begin
            is_arith = 1'b0;
         end
      endcase
      // Borrow forms take the carry flag, plain forms a fixed one
      if (req_in.op == iops_pkg::IOPS_REVERSED_BORROW_DIFFERENCE_OP ||
          req_in.op == iops_pkg::IOPS_BORROW_DIFFERENCE_OP) begin
         arith = add_c(arith_a, arith_b, carry);
      end else begin
         arith = add_c(arith_a, arith_b, 1'b1);
      end
   end

   logic take;
   logic test_op;
   logic [31:0] flag_res;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.resp.reg_we = 1'b0;
      next_r.resp.mem_we = 1'b0;
      next_r.resp.mem_re = 1'b0;
      next_r.resp.copro_we = 1'b0;
      take = req_valid_in && r.st == iops_pkg::IOPS_IDLE;
      test_op = req_in.op == iops_pkg::IOPS_XOR_TEST_OP ||
                req_in.op == iops_pkg::IOPS_AND_TEST_OP;
      flag_res = is_arith ? arith[31:0] : logic_res;
      unique case (r.st)
         iops_pkg::IOPS_IDLE: begin
            if (take) begin
               next_r.done = 1'b1;
               if ((is_arith || is_logic) && !test_op) begin
                  next_r.resp.reg_we = 1'b1;
                  next_r.resp.reg_wdata = flag_res;
               end
               // Tests always update flags, others only on set bit
               if ((is_arith || is_logic) && (req_in.set_flags || test_op)) begin
                  next_r.status_word[`IOPS_FLAG_N] = flag_res[`IOPS_MSB];
                  next_r.status_word[`IOPS_FLAG_Z] = flag_res == `IOPS_ZERO;
                  if (is_arith) begin
                     next_r.status_word[`IOPS_FLAG_C] = arith[32];
                     next_r.status_word[`IOPS_FLAG_V] = (arith_a[31] == arith_b[31]) &&
                                               (arith[31] != arith_a[31]);
                  end
               end
               unique case (req_in.op)
                  iops_pkg::IOPS_WORD_LOAD_OP: begin
                     next_r.resp.mem_re = 1'b1;
                     next_r.resp.mem_addr = req_in.address;
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = req_in.mem_rdata;
                  end
                  iops_pkg::IOPS_WORD_STORE_OP: begin
                     next_r.resp.mem_we = 1'b1;
                     next_r.resp.mem_addr = req_in.address;
                     next_r.resp.mem_wdata = req_in.second_src_reg;
                  end
                  iops_pkg::IOPS_CPU_TO_COPRO_OP: begin
                     next_r.resp.copro_we = 1'b1;
                     next_r.resp.copro_wdata = req_in.copro_combine ?
                        (req_in.first_operand_reg | req_in.copro_extra_reg) :
                        req_in.first_operand_reg;
                  end
                  iops_pkg::IOPS_COPRO_TO_CPU_OP: begin
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = copro_val;
                  end
                  iops_pkg::IOPS_PRODUCT_OP: begin
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = product;
                  end
                  iops_pkg::IOPS_PRODUCT_ACCUMULATE_OP: begin
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = product + req_in.dest_old;
                  end
                  iops_pkg::IOPS_STATUS_TO_REG_OP: begin
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = r.status_word;
                  end
                  iops_pkg::IOPS_REG_TO_STATUS_OP: begin
                     if (req_in.flags_only) begin
                        next_r.status_word = (r.status_word & ~`IOPS_FLAG_MASK) |
                                     (req_in.second_src_reg & `IOPS_FLAG_MASK);
                     end else begin
                        next_r.status_word = req_in.second_src_reg;
                     end
                  end
                  iops_pkg::IOPS_COPRO_STORE_OP: begin
                     next_r.resp.mem_we = 1'b1;
                     next_r.resp.mem_addr = req_in.address;
                     next_r.resp.mem_wdata = req_in.copro_target_reg;
                  end
                  iops_pkg::IOPS_BLOCK_STORE_OP: begin
                     if (req_in.reg_list != 16'h0000) begin
                        next_r.done = 1'b0;
                        next_r.st = iops_pkg::IOPS_BLOCK;
                        next_r.pending = req_in.reg_list;
                        next_r.next_addr = req_in.address;
                        next_r.resp.store_index = lowest_bit(req_in.reg_list);
                        next_r.resp.busy = 1'b1;
                     end
                  end
                  iops_pkg::IOPS_ATOMIC_EXCHANGE_OP: begin
                     next_r.done = 1'b0;
                     next_r.resp.mem_re = 1'b1;
                     next_r.resp.mem_addr = req_in.first_operand_reg;
                     next_r.resp.reg_we = 1'b1;
                     next_r.resp.reg_wdata = req_in.mem_rdata;
                     next_r.swap_data = req_in.second_src_reg;
                     next_r.st = iops_pkg::IOPS_SWAP_WR;
                     next_r.resp.busy = 1'b1;
                  end
                  default: begin
                     next_r.resp.busy = 1'b0;
                  end
               endcase
            end
         end
         iops_pkg::IOPS_BLOCK: begin
            // One register per cycle, ascending index at ascending address
            next_r.resp.mem_we = 1'b1;
            next_r.resp.mem_addr = r.next_addr;
            next_r.resp.mem_wdata = block_data_in;
            next_r.next_addr = r.next_addr + 32'h0000_0004;
            next_r.pending = clear_lowest(r.pending);
            next_r.resp.store_index = lowest_bit(clear_lowest(r.pending));
            if (clear_lowest(r.pending) == 16'h0000) begin
               next_r.st = iops_pkg::IOPS_IDLE;
               next_r.resp.busy = 1'b0;
               next_r.done = 1'b1;
            end
         end
         iops_pkg::IOPS_SWAP_WR: begin
            // Write half of the exchange, same word, no request taken between
            next_r.resp.mem_we = 1'b1;
            next_r.resp.mem_wdata = r.swap_data;
            next_r.st = iops_pkg::IOPS_IDLE;
            next_r.resp.busy = 1'b0;
            next_r.done = 1'b1;
         end
         default: begin
            next_r.st = iops_pkg::IOPS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         r <= '0;
         r.status_word <= `IOPS_PSR_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign resp_out = r.resp;
   assign done_out = r.done;
   assign psr_out = r.status_word;
endmodule

// File: design/iops_params.svh
`ifndef IOPS_PARAMS_SVH
`define IOPS_PARAMS_SVH
`define IOPS_WIDTH 32
`define IOPS_MSB 31
`define IOPS_FLAG_N 31
`define IOPS_FLAG_Z 30
`define IOPS_FLAG_C 29
`define IOPS_FLAG_V 28
`define IOPS_PSR_RESET 32'h0000_00d3
`define IOPS_FLAG_MASK 32'hf000_0000
`define IOPS_ZERO 32'h0000_0000
`define IOPS_ONES 32'hffff_ffff
`endif

// File: design/iops_pkg.sv
package iops_pkg;
   typedef enum logic [4:0] {
      IOPS_NOP,
      IOPS_WORD_LOAD_OP,
      IOPS_WORD_STORE_OP,
      IOPS_CPU_TO_COPRO_OP,
      IOPS_COPRO_TO_CPU_OP,
      IOPS_PRODUCT_OP,
      IOPS_PRODUCT_ACCUMULATE_OP,
      IOPS_COPY_OP,
      IOPS_INVERTED_COPY_OP,
      IOPS_BITWISE_OR_OP,
      IOPS_STATUS_TO_REG_OP,
      IOPS_REG_TO_STATUS_OP,
      IOPS_REVERSED_DIFFERENCE_OP,
      IOPS_REVERSED_BORROW_DIFFERENCE_OP,
      IOPS_DIFFERENCE_OP,
      IOPS_BORROW_DIFFERENCE_OP,
      IOPS_COPRO_STORE_OP,
      IOPS_BLOCK_STORE_OP,
      IOPS_ATOMIC_EXCHANGE_OP,
      IOPS_XOR_TEST_OP,
      IOPS_AND_TEST_OP
   } iops_op_t;

   typedef struct packed {
      iops_op_t op;
      logic set_flags;
      logic flags_only;
      logic [31:0] first_operand_reg;
      logic [31:0] second_operand;
      logic [31:0] second_src_reg;
      logic [31:0] multiplier_reg;
      logic [31:0] dest_old;
      logic [31:0] copro_target_reg;
      logic [31:0] copro_extra_reg;
      logic copro_combine;
      logic [31:0] address;
      logic [31:0] mem_rdata;
      logic [15:0] reg_list;
   } iops_req_t;

   typedef struct packed {
      logic reg_we;
      logic [31:0] reg_wdata;
      logic mem_we;
      logic mem_re;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic copro_we;
      logic [31:0] copro_wdata;
      logic [3:0] store_index;
      logic busy;
   } iops_resp_t;

   typedef enum logic [1:0] {
      IOPS_IDLE,
      IOPS_BLOCK,
      IOPS_SWAP_WR
   } iops_state_t;

   typedef struct packed {
      iops_state_t st;
      iops_resp_t resp;
      logic [31:0] status_word;
      logic [15:0] pending;
      logic [31:0] next_addr;
      logic [31:0] swap_data;
      logic done;
   } iops_regs_t;
endpackage
